//--- rtl/rtcam_defines.svh
// Purpose: Register offsets, bit positions and reset values of the alarm block
// Assumes: Included by its bare name from the design modules
// Notes: Definitions only
`ifndef RTCAM_DEFINES_SVH
`define RTCAM_DEFINES_SVH

// Register offsets on the register port
`define RTCAM_OFS_A0_SEC 8'h0c
`define RTCAM_OFS_A0_MIN 8'h0d
`define RTCAM_OFS_A0_HOUR 8'h0e
`define RTCAM_OFS_A0_WKDAY 8'h0f
`define RTCAM_OFS_A0_DATE 8'h10
`define RTCAM_OFS_A0_MONTH 8'h11
`define RTCAM_OFS_A1_HSEC 8'h12
`define RTCAM_OFS_A1_SEC 8'h13
`define RTCAM_OFS_A1_MIN 8'h14
`define RTCAM_OFS_A1_HOUR 8'h15
`define RTCAM_OFS_A1_WKDAY 8'h16
`define RTCAM_OFS_A1_DATE 8'h17

// Field positions
`define RTCAM_PIN_BIT 7
`define RTCAM_MASK_HI 6
`define RTCAM_MASK_LO 4
`define RTCAM_FLAG_BIT 3
`define RTCAM_FMT_BIT 6

// Reset values
`define RTCAM_RST_ZERO 8'h00
`define RTCAM_RST_ONE 8'h01

`endif

//--- rtl/rtcam_pkg.sv
// Purpose: Types shared by the alarm block
// Assumes: Time fields arrive as packed BCD bytes laid out as in the timekeeping registers
// Notes: Offsets and positions live in rtcam_defines.svh
package rtcam_pkg;

    // Running timekeeping values, one BCD byte per quantity
    typedef struct packed {
        logic [7:0] hsec;
        logic [7:0] sec;
        logic [7:0] min;
        logic [7:0] hour;
        logic [7:0] wkday;
        logic [7:0] date;
        logic [7:0] month;
    } rtcam_time_t;

    // Alarm field selection codes
    typedef enum logic [2:0] {
        RTCAM_SEL_SEC = 3'h0,
        RTCAM_SEL_MIN = 3'h1,
        RTCAM_SEL_HOUR = 3'h2,
        RTCAM_SEL_WKDAY = 3'h3,
        RTCAM_SEL_DATE = 3'h4,
        RTCAM_SEL_HSEC = 3'h5,
        RTCAM_SEL_RSVD = 3'h6,
        RTCAM_SEL_ALL = 3'h7
    } rtcam_sel_t;

    // Stored match values of one alarm
    typedef struct packed {
        logic [7:0] hsec;
        logic [7:0] sec;
        logic [7:0] min;
        logic [7:0] hour;
        logic [7:0] wkday;
        logic [7:0] date;
        logic [7:0] month;
    } rtcam_match_t;

endpackage

//--- rtl/rtcam_alarm_unit.sv
// Purpose: One alarm comparator with its sticky match flag
// Assumes: Match values are valid BCD; time_tick pulses once per counter update
// Notes: SECOND_ALARM picks centisecond matching instead of month matching
`timescale 1ns/10ps
`include "rtcam_defines.svh"

module rtcam_alarm_unit
    import rtcam_pkg::*;
#(
    parameter bit SECOND_ALARM = 1'b0
) (
    input wire logic clk, // System clock
    input wire logic rst, // Asynchronous reset, active high
    input wire rtcam_time_t now, // Running time values
    input wire logic time_tick, // Counter update pulse
    input wire logic arm, // Alarm enable level
    input wire rtcam_match_t match_val, // Stored match values
    input wire rtcam_sel_t field_sel, // Field selection
    input wire logic flag_clr, // Host clears the flag
    output logic flag // Sticky match flag
);

    logic flag_reg;
    logic flag_next;
    logic prev_reg;
    logic prev_next;
    logic eq_sec, eq_min, eq_hour, eq_wkday, eq_date, eq_month, eq_hsec;
    logic match_now;
    logic flag_set;

    // Per-field BCD equality, unimplemented bits left out
    assign eq_sec = now.sec[6:0] == match_val.sec[6:0];
    assign eq_min = now.min[6:0] == match_val.min[6:0];
    assign eq_hour = now.hour[5:0] == match_val.hour[5:0];
    assign eq_wkday = now.wkday[2:0] == match_val.wkday[2:0];
    assign eq_date = now.date[5:0] == match_val.date[5:0];
    assign eq_month = now.month[4:0] == match_val.month[4:0];
    assign eq_hsec = now.hsec == match_val.hsec;

    // Mask decode; the reserved codes never match so a bad setting stays quiet
    assign match_now =
        (field_sel == RTCAM_SEL_SEC && eq_sec) ||
        (field_sel == RTCAM_SEL_MIN && eq_min) ||
        (field_sel == RTCAM_SEL_HOUR && eq_hour) ||
        (field_sel == RTCAM_SEL_WKDAY && eq_wkday) ||
        (field_sel == RTCAM_SEL_DATE && eq_date) ||
        (SECOND_ALARM && field_sel == RTCAM_SEL_HSEC && eq_hsec) ||
        (field_sel == RTCAM_SEL_ALL && eq_sec && eq_min && eq_hour && eq_wkday
            && eq_date && (SECOND_ALARM || eq_month));

    // Fire only on the update where the match first appears
    assign flag_set = time_tick && arm && match_now && !prev_reg;
    assign prev_next = time_tick ? match_now : prev_reg;
    // Set beats a clear arriving in the same cycle; only hardware sets
    assign flag_next = flag_set || (flag_reg && !flag_clr);
    assign flag = flag_reg;

    // Flag and match history
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            flag_reg <= 1'b0;
            prev_reg <= 1'b0;
        end else begin
            flag_reg <= flag_next;
            prev_reg <= prev_next;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_flag_on_match: assert property (time_tick && arm && match_now && !prev_reg |=> flag_reg)
        else $error("flag not set on fresh match");
    a_flag_sticky: assert property (flag_reg && !flag_clr |=> flag_reg)
        else $error("flag dropped without a clear");
    a_flag_cleared: assert property (flag_clr && !flag_set |=> !flag_reg)
        else $error("flag survived a clear");
    a_disarmed_quiet: assert property (!flag_reg && !arm |=> !flag_reg)
        else $error("flag set while disarmed");
    a_no_refire: assert property (time_tick && match_now ##1 time_tick && match_now
        |-> !flag_set)
        else $error("flag set twice for one match");
    a_rsvd_quiet: assert property (field_sel == RTCAM_SEL_RSVD |-> !match_now)
        else $error("reserved selection matched");

endmodule // rtcam_alarm_unit

//--- rtl/rtcam_dual_alarm.sv
// Purpose: Two independent alarm units with their match registers and pin routing
// Assumes: Register port and time inputs synchronous to clk; arm bits held elsewhere
// Notes: Pins are active low and driven from flops
`timescale 1ns/10ps
`include "rtcam_defines.svh"

module rtcam_dual_alarm
    import rtcam_pkg::*;
(
    input wire logic clk, // System clock, 25 MHz
    input wire logic rst, // Asynchronous reset, active high
    input wire logic [7:0] reg_addr, // Register address
    input wire logic reg_wr, // Write strobe, one cycle
    input wire logic [7:0] reg_wdata, // Write data
    input wire logic reg_rd, // Read strobe, one cycle
    output logic [7:0] reg_rdata, // Read data, valid the cycle after reg_rd
    input wire rtcam_time_t now, // Running timekeeping values
    input wire logic time_tick, // One pulse per counter update
    input wire logic [1:0] alarm_arm_bit, // Alarm enables from the control register
    output logic alarm_irq_pin_n, // Interrupt request pin, low when asserted
    output logic watchdog_output_pin_n, // Alarm share of the watchdog pin, low active
    output logic [1:0] alarm_match_flag // Flags, for the host's convenience
);

    localparam int NUM_ALARMS = 2;
    localparam logic [7:0] OFS_SEC [NUM_ALARMS] = '{`RTCAM_OFS_A0_SEC, `RTCAM_OFS_A1_SEC};
    localparam logic [7:0] OFS_MIN [NUM_ALARMS] = '{`RTCAM_OFS_A0_MIN, `RTCAM_OFS_A1_MIN};
    localparam logic [7:0] OFS_HOUR [NUM_ALARMS] = '{`RTCAM_OFS_A0_HOUR, `RTCAM_OFS_A1_HOUR};
    localparam logic [7:0] OFS_WKDAY [NUM_ALARMS] =
        '{`RTCAM_OFS_A0_WKDAY, `RTCAM_OFS_A1_WKDAY};
    localparam logic [7:0] OFS_DATE [NUM_ALARMS] = '{`RTCAM_OFS_A0_DATE, `RTCAM_OFS_A1_DATE};

    // Per-alarm storage, arrays indexed by alarm number; month_reg and hsec_reg held once
    logic [6:0] sec_reg [NUM_ALARMS];
    logic [6:0] min_reg [NUM_ALARMS];
    logic [5:0] hour_reg [NUM_ALARMS];
    logic [7:0] cfg_reg [NUM_ALARMS]; // Pin, mask and weekday; bit 3 unused here
    logic [5:0] date_reg [NUM_ALARMS];
    logic [4:0] month_reg;
    logic [7:0] hsec_reg;

    logic [NUM_ALARMS-1:0] flag;
    logic [NUM_ALARMS-1:0] flag_clr;
    logic [NUM_ALARMS-1:0] live;
    logic [NUM_ALARMS-1:0] wr_sec, wr_min, wr_hour, wr_wkday, wr_date;
    logic wr_month;
    logic wr_hsec;
    logic [7:0] rd_mux;
    logic [7:0] rdata_next;
    logic irq_next;
    logic wdo_next;
    logic irq_pin_reg;
    logic wdo_pin_reg;
    logic [7:0] rdata_reg;

    // Write decode for the single-instance registers
    assign wr_month = reg_wr && reg_addr == `RTCAM_OFS_A0_MONTH;
    assign wr_hsec = reg_wr && reg_addr == `RTCAM_OFS_A1_HSEC;

    // One alarm per iteration: decode, storage and comparator
    for (genvar i = 0; i < NUM_ALARMS; i++) begin : g_alarm
        rtcam_match_t mv;
        rtcam_sel_t sel;

        assign wr_sec[i] = reg_wr && reg_addr == OFS_SEC[i];
        assign wr_min[i] = reg_wr && reg_addr == OFS_MIN[i];
        assign wr_hour[i] = reg_wr && reg_addr == OFS_HOUR[i];
        assign wr_wkday[i] = reg_wr && reg_addr == OFS_WKDAY[i];
        assign wr_date[i] = reg_wr && reg_addr == OFS_DATE[i];
        // A zero in the flag position clears; a one is simply dropped
        assign flag_clr[i] = wr_wkday[i] && !reg_wdata[`RTCAM_FLAG_BIT];

        assign mv.hsec = (i == 1) ? hsec_reg : `RTCAM_RST_ZERO;
        assign mv.sec = {1'b0, sec_reg[i]};
        assign mv.min = {1'b0, min_reg[i]};
        assign mv.hour = {2'b00, hour_reg[i]};
        assign mv.wkday = {5'b00000, cfg_reg[i][2:0]};
        assign mv.date = {2'b00, date_reg[i]};
        assign mv.month = (i == 0) ? {3'b000, month_reg} : `RTCAM_RST_ZERO;
        assign sel = rtcam_sel_t'(cfg_reg[i][`RTCAM_MASK_HI:`RTCAM_MASK_LO]);
        // Output is live only while the alarm is armed and its flag stands
        assign live[i] = flag[i] && alarm_arm_bit[i];

        // Match registers; unimplemented bits are never stored
        always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
                sec_reg[i] <= 7'h00;
                min_reg[i] <= 7'h00;
                hour_reg[i] <= 6'h00;
                cfg_reg[i] <= `RTCAM_RST_ONE;
                date_reg[i] <= 6'h01;
            end else begin
                if (wr_sec[i]) sec_reg[i] <= reg_wdata[6:0];
                if (wr_min[i]) min_reg[i] <= reg_wdata[6:0];
                if (wr_hour[i]) hour_reg[i] <= reg_wdata[5:0];
                if (wr_wkday[i]) cfg_reg[i] <= {reg_wdata[7:4], 1'b0, reg_wdata[2:0]};
                if (wr_date[i]) date_reg[i] <= reg_wdata[5:0];
            end
        end

        rtcam_alarm_unit #(
            .SECOND_ALARM(i == 1)
        ) u_unit (
            .clk(clk),
            .rst(rst),
            .now(now),
            .time_tick(time_tick),
            .arm(alarm_arm_bit[i]),
            .match_val(mv),
            .field_sel(sel),
            .flag_clr(flag_clr[i]),
            .flag(flag[i])
        );
    end

    // Registers that exist for one alarm only
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            month_reg <= 5'h01;
            hsec_reg <= `RTCAM_RST_ZERO;
        end else begin
            if (wr_month) month_reg <= reg_wdata[4:0];
            if (wr_hsec) hsec_reg <= reg_wdata;
        end
    end

    // Read selection; unmapped addresses and unimplemented bits return zero
    always_comb begin
        rd_mux = 8'h00;
        unique case (reg_addr)
            `RTCAM_OFS_A0_SEC: rd_mux = {1'b0, sec_reg[0]};
            `RTCAM_OFS_A1_SEC: rd_mux = {1'b0, sec_reg[1]};
            `RTCAM_OFS_A0_MIN: rd_mux = {1'b0, min_reg[0]};
            `RTCAM_OFS_A1_MIN: rd_mux = {1'b0, min_reg[1]};
            `RTCAM_OFS_A0_HOUR: rd_mux = {1'b0, now.hour[`RTCAM_FMT_BIT], hour_reg[0]};
            `RTCAM_OFS_A1_HOUR: rd_mux = {1'b0, now.hour[`RTCAM_FMT_BIT], hour_reg[1]};
            `RTCAM_OFS_A0_WKDAY: rd_mux = {cfg_reg[0][7:4], flag[0], cfg_reg[0][2:0]};
            `RTCAM_OFS_A1_WKDAY: rd_mux = {cfg_reg[1][7:4], flag[1], cfg_reg[1][2:0]};
            `RTCAM_OFS_A0_DATE: rd_mux = {2'b00, date_reg[0]};
            `RTCAM_OFS_A1_DATE: rd_mux = {2'b00, date_reg[1]};
            `RTCAM_OFS_A0_MONTH: rd_mux = {3'b000, month_reg};
            `RTCAM_OFS_A1_HSEC: rd_mux = hsec_reg;
            default: rd_mux = 8'h00;
        endcase
    end

    assign rdata_next = reg_rd ? rd_mux : rdata_reg;

    // Pin routing: either alarm can land on either pin, both may share one
    assign irq_next = !((live[0] && !cfg_reg[0][`RTCAM_PIN_BIT])
        || (live[1] && !cfg_reg[1][`RTCAM_PIN_BIT]));
    assign wdo_next = !((live[0] && cfg_reg[0][`RTCAM_PIN_BIT])
        || (live[1] && cfg_reg[1][`RTCAM_PIN_BIT]));

    // Output flops; no supply gating here so the pins work on backup power too
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            irq_pin_reg <= 1'b1;
            wdo_pin_reg <= 1'b1;
            rdata_reg <= `RTCAM_RST_ZERO;
        end else begin
            irq_pin_reg <= irq_next;
            wdo_pin_reg <= wdo_next;
            rdata_reg <= rdata_next;
        end
    end

    assign alarm_irq_pin_n = irq_pin_reg;
    assign watchdog_output_pin_n = wdo_pin_reg;
    assign reg_rdata = rdata_reg;
    assign alarm_match_flag = flag;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    // A write of one into the flag position, with no match around, leaves it clear
    sequence s_flag_idle;
        !flag[0] && !time_tick;
    endsequence

    sequence s_write_one;
        reg_wr && reg_addr == `RTCAM_OFS_A0_WKDAY && reg_wdata[`RTCAM_FLAG_BIT];
    endsequence

    a_no_soft_set: assert property (s_flag_idle and s_write_one |=> !flag[0])
        else $error("host write set the alarm flag");

    a_irq_route: assert property (flag[0] && alarm_arm_bit[0] && !cfg_reg[0][7]
        |=> !alarm_irq_pin_n)
        else $error("irq pin not driven for alarm 0");

    a_wdo_route: assert property (flag[1] && alarm_arm_bit[1] && cfg_reg[1][7]
        |=> !watchdog_output_pin_n)
        else $error("watchdog pin not driven for alarm 1");

    a_pins_idle: assert property (!flag[0] && !flag[1] |=> alarm_irq_pin_n
        && watchdog_output_pin_n)
        else $error("pin driven with no flag");

    a_hour_format: assert property (reg_rd && reg_addr == `RTCAM_OFS_A1_HOUR
        |=> reg_rdata[`RTCAM_FMT_BIT] == $past(now.hour[`RTCAM_FMT_BIT]))
        else $error("hour format bit not mirrored");

    a_sec_top_zero: assert property (reg_rd && (reg_addr == `RTCAM_OFS_A0_SEC
        || reg_addr == `RTCAM_OFS_A1_MIN) |=> reg_rdata[7] == 1'b0)
        else $error("unimplemented bit read as one");

    a_hsec_store: assert property (wr_hsec ##1 reg_rd && reg_addr == `RTCAM_OFS_A1_HSEC
        |=> reg_rdata == $past(reg_wdata, 2))
        else $error("centisecond register lost its value");

    a_month_clear: assert property (reg_wr && reg_addr == `RTCAM_OFS_A0_MONTH
        ##1 reg_rd && reg_addr == `RTCAM_OFS_A0_MONTH |=> reg_rdata[7:5] == 3'b000)
        else $error("month unimplemented bits not zero");

endmodule // rtcam_dual_alarm

//--- tb/rtcam_host_model.sv
// Purpose: Host side model that receives the two alarm pins
// Assumes: Both pins are active low and registered inside the block
// Notes: Counts falling edges so the bench can tell one set from many
`timescale 1ns/10ps

module rtcam_host_model (
    input wire logic clk, // System clock
    input wire logic rst, // Asynchronous reset, active high
    input wire logic irq_n, // Interrupt request pin
    input wire logic wdo_n, // Watchdog pin, alarm share
    output logic [7:0] irq_cnt_reg, // Falls seen on irq_n
    output logic [7:0] wdo_cnt_reg // Falls seen on wdo_n
);
    logic irq_last_reg;
    logic wdo_last_reg;

    // Count edges, not levels: a level-only host would miss a repeated set
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            irq_last_reg <= 1'b1;
            wdo_last_reg <= 1'b1;
            irq_cnt_reg <= 8'h00;
            wdo_cnt_reg <= 8'h00;
        end else begin
            irq_last_reg <= irq_n;
            wdo_last_reg <= wdo_n;
            irq_cnt_reg <= irq_cnt_reg + {7'h00, irq_last_reg & ~irq_n};
            wdo_cnt_reg <= wdo_cnt_reg + {7'h00, wdo_last_reg & ~wdo_n};
        end
    end
endmodule // rtcam_host_model

//--- tb/tb.sv
// Purpose: Self-checking bench for the dual alarm block
// Assumes: Registers reached by one-cycle strobes, read data one cycle later
// Notes: Each scenario arms at most one alarm, since mcase routes both alarms to the irq pin
`timescale 1ns/10ps

module tb;
    import rtcam_pkg::*;
    localparam rtcam_time_t SET = {8'h42, 8'h11, 8'h22, 8'h03, 8'h02, 8'h04, 8'h05};
    localparam rtcam_time_t FAR = {8'h97, 8'h59, 8'h58, 8'h23, 8'h07, 8'h31, 8'h12};
    logic clk, rst, reg_wr, reg_rd, time_tick;
    logic [7:0] reg_addr, reg_wdata, rdata, irq_cnt, wdo_cnt, c;
    logic [1:0] arm, flags;
    logic irq_n, wdo_n;
    rtcam_time_t now_val, t;
    int n_mismatch, compares;

    rtcam_dual_alarm dut (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(rdata), .now(now_val),
        .time_tick(time_tick), .alarm_arm_bit(arm), .alarm_irq_pin_n(irq_n),
        .watchdog_output_pin_n(wdo_n), .alarm_match_flag(flags));
    rtcam_host_model host (.clk(clk), .rst(rst), .irq_n(irq_n), .wdo_n(wdo_n),
        .irq_cnt_reg(irq_cnt), .wdo_cnt_reg(wdo_cnt));

    // Free-running 25 MHz clock
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task automatic stop_test();
        if (n_mismatch == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // Register cycles: strobe for one edge, then drop it
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        chk(rdata, exp);
    endtask

    // One counter update, then let flag and pin settle
    task automatic tick(input rtcam_time_t tv);
        @(posedge clk);
        now_val <= tv;
        time_tick <= 1'b1;
        @(posedge clk);
        time_tick <= 1'b0;
        repeat (3) @(posedge clk);
        #1;
    endtask

    // Far time except one field, k: 0 centisec, 1 sec .. 6 month
    function automatic rtcam_time_t only(input int k);
        rtcam_time_t r;
        r = FAR;
        r[55-8*k -: 8] = SET[55-8*k -: 8];
        return r;
    endfunction

    // Arm in order: mask, pin and flag clear in one write, a far tick, enable, then the test tick
    task automatic mcase(input int u, input logic [2:0] m, input rtcam_time_t tv, input logic e);
        arm <= 2'b00;
        wr(u ? 8'h16 : 8'h0f, {1'b0, m, 4'h2});
        tick(FAR);
        arm <= 2'b01 << u;
        tick(tv);
        chk({7'h00, flags[u]}, {7'h00, e});
        chk({7'h00, irq_n}, {7'h00, ~e});
    endtask

    task automatic s_reset();
        chk({6'h00, irq_n, wdo_n}, 8'h03);
        rchk(8'h0c, 8'h00);
        rchk(8'h12, 8'h00);
        rchk(8'h0e, 8'h00);
        rchk(8'h0f, 8'h01);
        rchk(8'h16, 8'h01);
        rchk(8'h11, 8'h01);
        rchk(8'h20, 8'h00);
    endtask

    // Unimplemented bits drop writes; format bit follows timekeeping hours
    task automatic s_regs();
        wr(8'h13, 8'hff);
        rchk(8'h13, 8'h7f);
        wr(8'h14, 8'hff);
        rchk(8'h14, 8'h7f);
        wr(8'h12, 8'h99);
        rchk(8'h12, 8'h99);
        wr(8'h11, 8'hff);
        rchk(8'h11, 8'h1f);
        wr(8'h15, 8'hff);
        rchk(8'h15, 8'h3f);
        now_val.hour <= 8'h40;
        rchk(8'h15, 8'h7f);
        wr(8'h0f, 8'hff);
        rchk(8'h0f, 8'hf7);
    endtask

    task automatic load();
        wr(8'h0c, 8'h11);
        wr(8'h0d, 8'h22);
        wr(8'h0e, 8'h03);
        wr(8'h10, 8'h04);
        wr(8'h11, 8'h05);
        wr(8'h12, 8'h42);
        wr(8'h13, 8'h11);
        wr(8'h14, 8'h22);
        wr(8'h15, 8'h03);
        wr(8'h17, 8'h04);
    endtask

    task automatic s_masks();
        for (int u = 0; u < 2; u++) begin
            for (int m = 0; m < 5; m++) begin
                mcase(u, m[2:0], only(m + 1), 1'b1);
            end
        end
        mcase(0, 3'h5, only(0), 1'b0);
        mcase(1, 3'h5, only(0), 1'b1);
        mcase(0, 3'h6, SET, 1'b0);
        mcase(1, 3'h6, SET, 1'b0);
        mcase(0, 3'h7, SET, 1'b1);
        mcase(1, 3'h7, SET, 1'b1);
        mcase(0, 3'h7, only(0), 1'b0);
        t = SET;
        t.month = 8'h12;
        mcase(0, 3'h7, t, 1'b0);
        mcase(1, 3'h7, t, 1'b1);
    endtask

    // Twelve-hour values: afternoon bit and one-bit tens digit
    task automatic s_twelve();
        wr(8'h0e, 8'h32);
        t = only(3);
        t.hour = 8'h72;
        mcase(0, 3'h2, t, 1'b1);
        t.hour = 8'h52;
        mcase(0, 3'h2, t, 1'b0);
        wr(8'h0e, 8'h03);
    endtask

    task automatic s_pin();
        c = wdo_cnt;
        arm <= 2'b00;
        wr(8'h16, 8'h82);
        tick(FAR);
        arm <= 2'b10;
        tick(only(1));
        chk({6'h00, irq_n, wdo_n}, 8'h02);
        chk(wdo_cnt, c + 8'h01);
        wr(8'h16, 8'h02);
        repeat (3) @(posedge clk);
        #1;
        chk({6'h00, flags[1], wdo_n}, 8'h01);
    endtask

    // Held match sets once; flag sticks until a zero is written
    task automatic s_sticky();
        c = irq_cnt;
        mcase(0, 3'h0, only(1), 1'b1);
        tick(only(1));
        tick(only(1));
        tick(FAR);
        chk(irq_cnt, c + 8'h01);
        chk({7'h00, flags[0]}, 8'h01);
        wr(8'h0f, 8'h0a);
        rchk(8'h0f, 8'h0a);
        wr(8'h0f, 8'h02);
        repeat (3) @(posedge clk);
        #1;
        chk({6'h00, flags}, 8'h00);
        chk({7'h00, irq_n}, 8'h01);
        tick(only(1));
        chk({7'h00, flags[0]}, 8'h01);
        arm <= 2'b00;
        repeat (3) @(posedge clk);
        #1;
        chk({5'h00, flags, irq_n}, 8'h03);
        wr(8'h0f, 8'h02);
        tick(FAR);
        tick(only(1));
        chk({6'h00, flags}, 8'h00);
    endtask

    initial begin
        rst = 1'b1;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        time_tick = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        arm = 2'b00;
        now_val = FAR;
        n_mismatch = 0;
        compares = 0;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        s_reset();
        s_regs();
        now_val <= FAR;
        load();
        s_masks();
        s_twelve();
        s_pin();
        s_sticky();
        stop_test();
    end

    // Hang guard
    initial begin
        #3000000;
        n_mismatch++;
        stop_test();
    end
endmodule // tb
